// *** verilog/dcs_top.sv ***
// driver configuration register bank with serial host port and driver control
// assumes comparator and host pins asynchronous; sclk is an independent clock
`timescale 1ns/100ps
`include "dcs_params.svh"
module dcs_top #(
    parameter int BLANK0_CYC = `DCS_US2CYC(`DCS_T_BLANK0_US),
    parameter int BLANK1_CYC = `DCS_US2CYC(`DCS_T_BLANK1_US),
    parameter int BLANK2_CYC = `DCS_US2CYC(`DCS_T_BLANK2_US),
    parameter int BLANK3_CYC = `DCS_US2CYC(`DCS_T_BLANK3_US),
    parameter int RETRY0_CYC = `DCS_US2CYC(`DCS_T_RETRY0_US),
    parameter int RETRY1_CYC = `DCS_US2CYC(`DCS_T_RETRY1_US),
    parameter int RETRY2_CYC = `DCS_US2CYC(`DCS_T_RETRY2_US),
    parameter int RETRY3_CYC = `DCS_US2CYC(`DCS_T_RETRY3_US)
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    // serial port, host clocked
    input wire logic i_sclk,
    input wire logic i_chip_select_pin_n,
    input wire logic i_sdi,
    output logic o_sdo,
    // host logic pins
    input wire logic i_tx,
    input wire logic i_line_transmit_enable,
    input wire logic i_aux_out_level_in,
    // analog sense comparators
    input wire logic i_line_overcurrent,
    input wire logic i_aux_overcurrent,
    input wire logic i_line_overheat,
    input wire logic i_aux_overheat,
    input wire logic i_die_hot,
    input wire logic i_line_level,
    input wire logic i_aux_input_pin,
    // line port stage controls
    output logic o_line_hs_on,
    output logic o_line_ls_on,
    output logic o_line_weak_sink_enable,
    output logic o_line_weak_source_enable,
    output logic o_rx,
    output logic o_rx_oe,
    // aux port stage controls
    output logic o_aux_hs_on,
    output logic o_aux_ls_on,
    output logic o_aux_weak_sink_enable,
    output logic o_aux_weak_source_enable,
    output logic o_aux_in_level_out,
    output logic o_aux_in_level_oe,
    // current limit controls and fault flags
    output logic [1:0] o_limit_select,
    output logic o_limit_disable,
    output logic o_line_fault,
    output logic o_aux_fault
);
    localparam int TW = 25;
    localparam int BW = 18;

    initial begin
        if (BLANK3_CYC >= (1 << BW) || BLANK0_CYC < 1) $error("dcs_top: blanking count out of range");
        if (RETRY3_CYC >= (1 << TW) || RETRY0_CYC < 2) $error("dcs_top: retry count out of range");
    end

    dcs_pkg::dcs_byte_t limit_q, line_q, aux_q;
    logic [4:0] pin_s1_q, pin_s2_q;
    logic [4:0] sense_s1_q, sense_s2_q;
    logic tx_s, line_transmit_enable_s, lo_s, level_s, din_s;
    logic line_oc_s, aux_oc_s, line_hot_s, aux_hot_s, die_hot_s;
    logic wt1_q, wt2_q, wt3_q;
    logic [10:0] wr_word;
    logic wr_tgl;
    logic wr_take;
    logic [2:0] wr_addr;
    dcs_pkg::dcs_byte_t wr_data;
    logic [23:0] snap_q;
    logic snap_req_q;
    logic ack1_q, ack2_q;
    logic snap_ack;
    logic [23:0] regs_now;

    ////////////////////////////////////////////////////////////////
    // serial port in the sclk domain
    dcs_spi_link u_link (
        .i_sclk(i_sclk),
        .i_reset(i_reset),
        .i_cs_n(i_chip_select_pin_n),
        .i_sdi(i_sdi),
        .o_sdo(o_sdo),
        .o_wr_word(wr_word),
        .o_wr_tgl(wr_tgl),
        .i_snap(snap_q),
        .i_snap_req(snap_req_q),
        .o_snap_ack(snap_ack)
    );

    ////////////////////////////////////////////////////////////////
    // two-flop synchronisers for every asynchronous pin
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            pin_s1_q <= 5'h00;
            pin_s2_q <= 5'h00;
            sense_s1_q <= 5'h00;
            sense_s2_q <= 5'h00;
        end else if (i_ce) begin
            pin_s1_q <= {i_tx, i_line_transmit_enable, i_aux_out_level_in, i_line_level, i_aux_input_pin};
            pin_s2_q <= pin_s1_q;
            sense_s1_q <= {i_line_overcurrent, i_aux_overcurrent, i_line_overheat, i_aux_overheat, i_die_hot};
            sense_s2_q <= sense_s1_q;
        end
    end
    assign {tx_s, line_transmit_enable_s, lo_s, level_s, din_s} = pin_s2_q;
    assign {line_oc_s, aux_oc_s, line_hot_s, aux_hot_s, die_hot_s} = sense_s2_q;

    ////////////////////////////////////////////////////////////////
    // write event crossing: toggle through two flops, word is stable by then
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wt1_q <= 1'b0;
            wt2_q <= 1'b0;
            wt3_q <= 1'b0;
        end else if (i_ce) begin
            wt1_q <= wr_tgl;
            wt2_q <= wt1_q;
            wt3_q <= wt2_q;
        end
    end
    assign wr_take = wt2_q ^ wt3_q;
    assign wr_addr = wr_word[10:8];
    assign wr_data = wr_word[7:0];

    // register file; unmapped writes are dropped
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            limit_q <= `DCS_RST_LIMIT;
            line_q <= `DCS_RST_LINE; // driver starts disabled
            aux_q <= `DCS_RST_AUX;
        end else if (i_ce && wr_take) begin
            if (wr_addr == `DCS_ADDR_LIMIT) limit_q <= wr_data;
            if (wr_addr == `DCS_ADDR_LINE) line_q <= wr_data;
            if (wr_addr == `DCS_ADDR_AUX) aux_q <= wr_data;
        end
    end

    ////////////////////////////////////////////////////////////////
    // read snapshot crossing: request toggle, held word, ack returned
    assign regs_now = {aux_q, line_q, limit_q};
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            snap_q <= 24'h000000;
            snap_req_q <= 1'b0;
            ack1_q <= 1'b0;
            ack2_q <= 1'b0;
        end else if (i_ce) begin
            ack1_q <= snap_ack;
            ack2_q <= ack1_q;
            // a new word only once the previous one is acknowledged
            if (ack2_q == snap_req_q && snap_q != regs_now) begin
                snap_q <= regs_now;
                snap_req_q <= ~snap_req_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // field decode
    logic [1:0] lim_sel, blank_sel, retry_sel;
    logic lim_dis, retry_en;
    logic tracking, antivalent;
    assign lim_sel = limit_q[`DCS_B_LIM_LSB +: 2];
    assign lim_dis = limit_q[`DCS_B_LIMDIS];
    assign blank_sel = limit_q[`DCS_B_BLANK_LSB +: 2];
    assign retry_sel = limit_q[`DCS_B_RETRY_LSB +: 2];
    assign retry_en = limit_q[`DCS_B_RETRY_EN];
    assign tracking = line_q[`DCS_B_MODE];
    assign antivalent = aux_q[`DCS_B_MODE];

    // blanking length picked by the field
    logic [BW-1:0] blank_cyc;
    assign blank_cyc = (blank_sel == 2'h0) ? BW'(BLANK0_CYC) :
                       (blank_sel == 2'h1) ? BW'(BLANK1_CYC) :
                       (blank_sel == 2'h2) ? BW'(BLANK2_CYC) : BW'(BLANK3_CYC);
    logic [TW-1:0] retry_cyc;
    assign retry_cyc = (retry_sel == 2'h0) ? TW'(RETRY0_CYC) :
                       (retry_sel == 2'h1) ? TW'(RETRY1_CYC) :
                       (retry_sel == 2'h2) ? TW'(RETRY2_CYC) : TW'(RETRY3_CYC);

    ////////////////////////////////////////////////////////////////
    // blanking per driver: a condition must last the whole time to count
    logic [1:0] cond;
    logic [1:0] fault_hit;
    assign cond = {aux_oc_s | aux_hot_s, line_oc_s | line_hot_s};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_blank
            logic [BW-1:0] cnt_q;
            always_ff @(posedge i_mclk) begin
                if (i_reset) begin
                    cnt_q <= '0;
                end else if (i_ce) begin
                    if (!cond[gi]) cnt_q <= '0;
                    else if (cnt_q < blank_cyc) cnt_q <= cnt_q + BW'(1);
                end
            end
            assign fault_hit[gi] = cond[gi] && (cnt_q >= blank_cyc - BW'(1));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////
    // protection state: off-time with retry, else wait for a cool die
    dcs_pkg::dcs_prot_e prot_q, prot_d;
    logic [1:0] off_q, off_d;
    logic tmr_load, tmr_done;
    always_comb begin
        prot_d = prot_q;
        off_d = off_q;
        tmr_load = 1'b0;
        case (prot_q)
            dcs_pkg::DCS_RUN: begin
                if (fault_hit != 2'b00) begin
                    if (retry_en) begin
                        off_d = 2'b11; // both drivers off
                        tmr_load = 1'b1;
                        prot_d = dcs_pkg::DCS_OFF;
                    end else begin
                        off_d = fault_hit; // only the faulted driver
                        prot_d = dcs_pkg::DCS_COOL;
                    end
                end
            end
            dcs_pkg::DCS_OFF: begin
                if (tmr_done) begin
                    off_d = 2'b00; // back on without the host
                    prot_d = dcs_pkg::DCS_RUN;
                end
            end
            dcs_pkg::DCS_COOL: begin
                if (!die_hot_s) begin
                    off_d = 2'b00; // below hysteresis again
                    prot_d = dcs_pkg::DCS_RUN;
                end
            end
            default: begin
                off_d = 2'b00;
                prot_d = dcs_pkg::DCS_RUN;
            end
        endcase
    end
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            prot_q <= dcs_pkg::DCS_RUN;
            off_q <= 2'b00;
        end else if (i_ce) begin
            prot_q <= prot_d;
            off_q <= off_d;
        end
    end

    // long off-time counter
    dcs_off_timer #(
        .WIDTH(TW)
    ) u_timer (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_load(tmr_load),
        .i_count(retry_cyc),
        .o_done(tmr_done)
    );

    ////////////////////////////////////////////////////////////////
    // line port level and enable
    logic line_level, line_act;
    assign line_level = line_q[`DCS_B_OUT] | ~tx_s;
    assign line_act = ~line_q[`DCS_B_DIS] & ~off_q[0]
                      & (line_q[`DCS_B_OUT] | line_transmit_enable_s);

    // aux port: own source, or the line source when tracking
    logic aux_base, aux_level, aux_act;
    assign aux_base = tracking ? line_level : (aux_q[`DCS_B_OUT] | ~lo_s);
    assign aux_level = antivalent ? ~aux_base : aux_base;
    assign aux_act = ~aux_q[`DCS_B_DIS] & ~off_q[1];

    // stage switch mapping shared by both ports
    function automatic logic [1:0] stage_map(input logic act, input logic lvl, input logic pp, input logic sink);
        logic [1:0] sw;
        sw = 2'b00;
        if (act && pp) sw = lvl ? 2'b10 : 2'b01; // push-pull, sink mode ignored
        else if (act && sink) sw = lvl ? 2'b00 : 2'b01; // low-side: level one is off
        else if (act) sw = lvl ? 2'b10 : 2'b00; // high-side: level one is on
        return sw;
    endfunction
    logic [1:0] line_sw, aux_sw;
    assign line_sw = stage_map(line_act, line_level, line_q[`DCS_B_PP], line_q[`DCS_B_SINK]);
    assign aux_sw = stage_map(aux_act, aux_level, aux_q[`DCS_B_PP], aux_q[`DCS_B_SINK]);

    ////////////////////////////////////////////////////////////////
    // registered outputs; high and low switches never on together
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_line_hs_on <= 1'b0;
            o_line_ls_on <= 1'b0;
            o_aux_hs_on <= 1'b0;
            o_aux_ls_on <= 1'b0;
            o_line_weak_sink_enable <= 1'b0;
            o_line_weak_source_enable <= 1'b0;
            o_aux_weak_sink_enable <= 1'b0;
            o_aux_weak_source_enable <= 1'b0;
            o_rx <= 1'b0;
            o_rx_oe <= 1'b0;
            o_aux_in_level_out <= 1'b0;
            o_aux_in_level_oe <= 1'b0;
            o_limit_select <= 2'h0;
            o_limit_disable <= 1'b0;
            o_line_fault <= 1'b0;
            o_aux_fault <= 1'b0;
        end else if (i_ce) begin
            {o_line_hs_on, o_line_ls_on} <= line_sw;
            {o_aux_hs_on, o_aux_ls_on} <= aux_sw;
            o_line_weak_sink_enable <= line_q[`DCS_B_WSINK];
            o_line_weak_source_enable <= line_q[`DCS_B_SRC];
            o_aux_weak_sink_enable <= aux_q[`DCS_B_WSINK];
            o_aux_weak_source_enable <= aux_q[`DCS_B_SRC];
            o_rx <= level_s;
            o_rx_oe <= ~line_q[`DCS_B_RXDIS];
            o_aux_in_level_out <= din_s & ~aux_q[`DCS_B_RXDIS]; // receiver off reads low
            o_aux_in_level_oe <= ~aux_q[`DCS_B_RXDIS];
            o_limit_select <= lim_sel;
            o_limit_disable <= lim_dis;
            o_line_fault <= off_q[0];
            o_aux_fault <= off_q[1];
        end
    end
endmodule

// *** pkg/dcs_params.svh ***
// constants of the driver configuration register bank: offsets, fields, resets, times
// assumes a 40 MHz system clock; included by its bare name
//
// What this block does
// - limit select field picks 50, 100, 200 or 250 mA while limit enabled
// - limit-disable bit removes current limiting from both drivers
// - blanking field sets 128us, 500us, 1ms or 5ms before a fault counts
// - retry field sets off-time 50, 100, 200 or 500 ms
// - auto-retry on: both drivers off for off-time, then back on alone
// - auto-retry off: faulted driver returns only once the die has cooled
// - receiver-disable bit puts the line receive output in high impedance
// - two line weak-pull bits each switch their own sink or source
// - tracking bit makes the aux output follow the line transmit source
// - line push-pull bit, else sink-mode picks low-side or high-side switch
// - line output bit one drives high: high switch on, low switch off; in low-side mode both off
// - output bit zero: high impedance unless enabled, else inverse of transmit
// - line disable forces high impedance and resets to one
// - aux input disable switches receiver off and floats its host output
// - two aux weak-pull bits each switch their own source or sink
// - antivalent bit inverts aux polarity, also when tracking
// - aux push-pull bit, else aux sink-mode picks low-side or high-side
// - aux output bit one forces on level, zero gives inverse of logic input
// - aux disable floats the aux output and resets to one
// - serial port is clock polarity 0 phase 0, at most 12 MHz
// - register address steps by one after every data byte of a burst
`ifndef DCS_PARAMS_SVH
`define DCS_PARAMS_SVH

`define DCS_CLK_HZ 40000000
`define DCS_ADDR_LIMIT 3'h3
`define DCS_ADDR_LINE 3'h4
`define DCS_ADDR_AUX 3'h5
`define DCS_RST_LIMIT 8'h00
`define DCS_RST_LINE 8'h01
`define DCS_RST_AUX 8'h01
// command byte layout
`define DCS_CMD_READ 7
`define DCS_CMD_ADDR_LSB 0
// field positions shared by both config registers
`define DCS_B_DIS 0
`define DCS_B_OUT 1
`define DCS_B_PP 2
`define DCS_B_SINK 3
`define DCS_B_MODE 4
`define DCS_B_SRC 5
`define DCS_B_WSINK 6
`define DCS_B_RXDIS 7
// limit register fields
`define DCS_B_RETRY_EN 0
`define DCS_B_RETRY_LSB 1
`define DCS_B_BLANK_LSB 3
`define DCS_B_LIMDIS 5
`define DCS_B_LIM_LSB 6
// times in microseconds, counts derived at 40 MHz
`define DCS_T_BLANK0_US 128
`define DCS_T_BLANK1_US 500
`define DCS_T_BLANK2_US 1000
`define DCS_T_BLANK3_US 5000
`define DCS_T_RETRY0_US 50000
`define DCS_T_RETRY1_US 100000
`define DCS_T_RETRY2_US 200000
`define DCS_T_RETRY3_US 500000
`define DCS_US2CYC(t) ((t) * (`DCS_CLK_HZ / 1000000))

`endif

// *** pkg/dcs_pkg.sv ***
// types of the driver configuration register bank
// assumes nothing beyond a SystemVerilog compiler
package dcs_pkg;
    typedef logic [7:0] dcs_byte_t;
    // protection state, gray coded along run -> off -> wait-cool
    typedef enum logic [1:0] {
        DCS_RUN = 2'b00,
        DCS_OFF = 2'b01,
        DCS_COOL = 2'b11
    } dcs_prot_e;
endpackage

// *** verilog/dcs_spi_link.sv ***
// serial port logic on the host serial clock: command decode, burst, shifting
// assumes chip select low for a whole burst; reset may arrive without sclk running
`timescale 1ns/100ps
`include "dcs_params.svh"
module dcs_spi_link (
    input wire logic i_sclk,
    input wire logic i_reset,
    input wire logic i_cs_n,
    input wire logic i_sdi,
    output logic o_sdo,
    output logic [10:0] o_wr_word,
    output logic o_wr_tgl,
    input wire logic [23:0] i_snap,
    input wire logic i_snap_req,
    output logic o_snap_ack
);
    logic [2:0] bit_q;
    logic [6:0] shin_q;
    logic cmd_q;
    logic rd_q;
    logic [2:0] addr_q;
    logic [7:0] out_q;
    logic req1_q, req2_q;
    logic [23:0] copy_q;
    logic [7:0] rbyte;
    logic byte_end;
    logic [7:0] rx_byte;
    logic [10:0] wr_word_q;
    logic wr_tgl_q;

    assign byte_end = (bit_q == 3'h7);
    assign rx_byte = {shin_q, i_sdi};
    // unmapped addresses read zero
    assign rbyte = (addr_q == `DCS_ADDR_LIMIT) ? copy_q[7:0] :
                   (addr_q == `DCS_ADDR_LINE) ? copy_q[15:8] :
                   (addr_q == `DCS_ADDR_AUX) ? copy_q[23:16] : 8'h00;
    ////////////////////////////////////////////////////////////////
    // frame state, cleared while chip select is high
    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            bit_q <= 3'h0;
            shin_q <= 7'h00;
            cmd_q <= 1'b0;
            rd_q <= 1'b0;
            addr_q <= 3'h0;
        end else begin
            bit_q <= bit_q + 3'h1;
            shin_q <= rx_byte[6:0]; // sample on rising edge
            if (byte_end && !cmd_q) begin
                cmd_q <= 1'b1;
                rd_q <= rx_byte[`DCS_CMD_READ];
                addr_q <= rx_byte[`DCS_CMD_ADDR_LSB +: 3];
            end else if (byte_end) begin
                addr_q <= addr_q + 3'h1;
            end
        end
    end
    // output shifts on falling edge, next byte loaded at its boundary
    always_ff @(negedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            out_q <= 8'h00;
        end else if (bit_q == 3'h0 && cmd_q && rd_q) begin
            out_q <= rbyte;
        end else begin
            out_q <= {out_q[6:0], 1'b0};
        end
    end
    ////////////////////////////////////////////////////////////////
    // write word held stable across a byte, event carried by a toggle
    always_ff @(posedge i_sclk or posedge i_reset) begin
        if (i_reset) begin
            wr_word_q <= 11'h000;
            wr_tgl_q <= 1'b0;
            req1_q <= 1'b0;
            req2_q <= 1'b0;
            o_snap_ack <= 1'b0;
            copy_q <= 24'h000000;
        end else begin
            if (!i_cs_n && byte_end && cmd_q && !rd_q) begin
                wr_word_q <= {addr_q, rx_byte};
                wr_tgl_q <= ~wr_tgl_q;
            end
            req1_q <= i_snap_req;
            req2_q <= req1_q;
            if (req2_q != o_snap_ack) begin
                copy_q <= i_snap; // stable while the request is open
                o_snap_ack <= req2_q;
            end
        end
    end
    assign o_sdo = out_q[7];
    assign o_wr_word = wr_word_q;
    assign o_wr_tgl = wr_tgl_q;
endmodule

// *** verilog/dcs_off_timer.sv ***
// down counter for the auto-retry off time
// assumes a load pulse with the cycle count, counts only while enabled
`timescale 1ns/100ps
module dcs_off_timer #(
    parameter int WIDTH = 25
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_load,
    input wire logic [WIDTH-1:0] i_count,
    output logic o_done
);
    logic [WIDTH-1:0] cnt_q;
    logic run_q;

    initial begin
        if (WIDTH < 2) $error("dcs_off_timer: WIDTH too small");
    end
    // done pulses once when the count runs out
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            cnt_q <= '0;
            run_q <= 1'b0;
            o_done <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (i_load) begin
                cnt_q <= i_count;
                run_q <= 1'b1;
            end else if (run_q && cnt_q <= WIDTH'(1)) begin
                run_q <= 1'b0;
                o_done <= 1'b1;
            end else if (run_q) begin
                cnt_q <= cnt_q - WIDTH'(1);
            end
        end
    end
endmodule

// *** bench/dcs_top_props.sv ***
// port checks of the driver configuration bank, mclk domain
// assumes dcs_top port names; bound to every dcs_top
`timescale 1ns/100ps
module dcs_top_props (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_line_overcurrent,
    input wire logic i_aux_overcurrent,
    input wire logic i_line_overheat,
    input wire logic i_aux_overheat,
    input wire logic o_line_hs_on,
    input wire logic o_line_ls_on,
    input wire logic o_aux_hs_on,
    input wire logic o_aux_ls_on,
    input wire logic o_aux_in_level_out,
    input wire logic o_aux_in_level_oe,
    input wire logic o_line_fault,
    input wire logic o_aux_fault
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_reset);
    ////////////////////////////////////////
    // shoot-through guard on both stages
    a_line_never_both: assert property (!(o_line_hs_on && o_line_ls_on))
        else $error("line high and low switch both on");
    a_aux_never_both: assert property (!(o_aux_hs_on && o_aux_ls_on))
        else $error("aux high and low switch both on");
    // a held fault must have switched the stage off
    a_line_fault_off: assert property (o_line_fault [*2] |-> !o_line_hs_on && !o_line_ls_on)
        else $error("line stage on while faulted");
    a_aux_fault_off: assert property (o_aux_fault [*2] |-> !o_aux_hs_on && !o_aux_ls_on)
        else $error("aux stage on while faulted");
    // both stages start disabled
    a_line_reset_off: assert property ($fell(i_reset) |-> (!o_line_hs_on && !o_line_ls_on) [*8])
        else $error("line stage on after reset");
    a_aux_reset_off: assert property ($fell(i_reset) |-> (!o_aux_hs_on && !o_aux_ls_on) [*8])
        else $error("aux stage on after reset");
    a_level_when_off: assert property (!o_aux_in_level_oe |-> !o_aux_in_level_out)
        else $error("aux input level driven while disabled");
    // no line fault without an earlier sense condition
    a_fault_blank: assert property ($rose(o_line_fault) |->
        $past(i_line_overcurrent || i_aux_overcurrent || i_line_overheat || i_aux_overheat, 5))
        else $error("line fault without a held condition");
endmodule
bind dcs_top dcs_top_props u_dcs_top_props (.*);

// *** bench/dcs_host_model.sv ***
// host serial master: mode 0 frames, 80 ns sclk period
// assumes the bank samples on rising, shifts on falling sclk
`timescale 1ns/100ps
module dcs_host_model (
    input wire logic i_sdo,
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_sdi,
    output logic [7:0] o_rd_byte,
    output logic o_rd_done
);
    logic [7:0] sh;
    initial begin
        o_sclk = 1'h0;
        o_cs_n = 1'h1;
        o_sdi = 1'h0;
        o_rd_done = 1'h0;
    end
    ////////////////////////////////////////
    // command then n bytes; sclk stands still outside frames
    task automatic frame(input logic [7:0] cmd, input logic [31:0] data, input int n);
        #80 o_cs_n = 1'h0;
        for (int b = 0; b <= n; b++) begin
            sh = (b == 0) ? cmd : data[39-8*b -: 8];
            for (int i = 7; i >= 0; i--) begin
                o_sdi = sh[i];
                #40 o_sclk = 1'h1;
                o_rd_byte = {o_rd_byte[6:0], i_sdo};
                #40 o_sclk = 1'h0;
            end
            if (b > 0 && cmd[7]) begin
                o_rd_done = 1'h1;
                #1 o_rd_done = 1'h0;
            end
        end
        #39 o_cs_n = 1'h1;
        o_sdi = ~o_sdi; // no stale bit
    endtask
endmodule

// *** bench/tb_top.sv ***
// self-checking bench of the driver configuration bank
// assumes the host model on the serial port; short counts
`timescale 1ns/100ps
module tb_top;
    logic i_mclk = 1'h0, i_reset = 1'h0, i_ce = 1'h1, i_sclk, i_chip_select_pin_n, i_sdi, o_sdo;
    logic i_tx = 1'h0, i_line_transmit_enable = 1'h0, i_aux_out_level_in = 1'h0, i_line_level = 1'h0;
    logic i_aux_input_pin = 1'h0, i_line_overcurrent = 1'h0, i_aux_overcurrent = 1'h0, i_die_hot = 1'h0;
    logic i_line_overheat = 1'h0, i_aux_overheat = 1'h0, o_line_hs_on, o_line_ls_on, o_rx, o_rx_oe;
    logic o_line_weak_sink_enable, o_line_weak_source_enable, o_aux_hs_on, o_aux_ls_on, o_aux_fault;
    logic o_aux_weak_sink_enable, o_aux_weak_source_enable, o_aux_in_level_out, o_aux_in_level_oe;
    logic o_limit_disable, o_line_fault, rd_done, lv, la, av;
    logic [1:0] o_limit_select;
    logic [7:0] rd_byte;
    logic [7:0] exp_q[$];
    logic [31:0] r;
    int miscompares = 0;
    int cmp_count = 0;
    wire any_f = o_line_fault | o_aux_fault;
    always #12.5 i_mclk = ~i_mclk;
    dcs_top #(.BLANK0_CYC(8), .BLANK1_CYC(16), .BLANK2_CYC(24), .BLANK3_CYC(32),
        .RETRY0_CYC(40), .RETRY1_CYC(60), .RETRY2_CYC(80), .RETRY3_CYC(100)) u_dcs_top (.*);
    dcs_host_model u_dcs_host_model (.i_sdo(o_sdo), .o_sclk(i_sclk), .o_cs_n(i_chip_select_pin_n),
        .o_sdi(i_sdi), .o_rd_byte(rd_byte), .o_rd_done(rd_done));
    ////////////////////////////////////////
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        miscompares += exp_q.size(); // lost reads
        $display("compares=%0d mismatches=%0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // note expected bytes, then read
    task automatic rd(input logic [7:0] cmd, input logic [31:0] d, input int n);
        for (int i = 0; i < n; i++) exp_q.push_back(d[31-8*i -: 8]);
        u_dcs_host_model.frame(cmd, ~d, n);
    endtask
    // bounded wait on the fault flags, count in [lo, hi]
    task automatic wait_fault(input logic want, input int lo, input int hi);
        int c = 0;
        while (any_f !== want && c <= hi) begin
            @(posedge i_mclk);
            #2;
            c++;
        end
        if (c > hi) begin
            miscompares++;
            conclude();
        end
        cmp(16'(c >= lo), 16'h1);
    endtask
    // reads return in order: oldest note is due
    always @(posedge rd_done) cmp(rd_byte, exp_q.size() > 0 ? exp_q.pop_front() : 16'hffff);
    ////////////////////////////////////////
    initial begin
        r = $urandom(32'hc2718b40);
        #1 i_reset = 1'h1;
        repeat (10) @(posedge i_mclk);
        #2 i_reset = 1'h0;
        repeat (12) @(posedge i_mclk);
        rd(8'h83, 32'h00010100, 4);
        // random settings and pins, burst from address 2
        for (int k = 0; k < 48; k++) begin
            r = $urandom();
            @(posedge i_mclk);
            #2 {i_tx, i_line_transmit_enable, i_aux_out_level_in, i_aux_input_pin, i_line_level} = r[20:16];
            u_dcs_host_model.frame(8'h02, {r[23:16], r[31:29], 5'h0, r[7:0], r[15:8]}, 4);
            rd(8'h82, {8'h00, r[31:29], 5'h0, r[7:0], r[15:8]}, 4);
            lv = r[1] | ~i_tx;
            la = ~r[0] & (r[1] | i_line_transmit_enable);
            av = (r[4] ? lv : (r[9] | ~i_aux_out_level_in)) ^ r[12];
            cmp({o_line_hs_on, o_line_ls_on, o_line_weak_sink_enable, o_line_weak_source_enable, o_rx_oe,
                o_aux_hs_on, o_aux_ls_on, o_aux_weak_sink_enable, o_aux_weak_source_enable, o_aux_in_level_out,
                o_aux_in_level_oe, o_limit_select, o_limit_disable, o_rx},
                {la & lv & (r[2] | ~r[3]), la & ~lv & (r[2] | r[3]), r[6:5], ~r[7], ~r[8] & av & (r[10] | ~r[11]),
                ~r[8] & ~av & (r[10] | r[11]), r[14:13], i_aux_input_pin & ~r[15], ~r[15], r[31:29], i_line_level});
        end
        // timed retry: blank 16, off 80, both stages driven high
        u_dcs_host_model.frame(8'h03, 32'h0d060600, 3);
        @(posedge i_mclk);
        #2 {i_line_overcurrent, i_line_overheat} = {r[0], ~r[0]};
        wait_fault(1'h1, 16, 22);
        {i_line_overcurrent, i_line_overheat} = 2'h0;
        #50 cmp({o_line_hs_on, o_aux_hs_on}, 16'h0);
        i_ce = 1'h0; // freeze stretches off-time
        #500 i_ce = 1'h1;
        wait_fault(1'h0, 76, 82);
        #75 cmp({o_line_hs_on, o_aux_hs_on}, 16'h3);
        // no retry: aux waits for a cool die
        u_dcs_host_model.frame(8'h03, 32'h08000000, 1);
        @(posedge i_mclk);
        #2 {i_die_hot, i_aux_overcurrent, i_aux_overheat} = {1'h1, r[1], ~r[1]};
        wait_fault(1'h1, 16, 22);
        {i_aux_overcurrent, i_aux_overheat} = 2'h0;
        #2500 cmp({o_aux_fault, o_line_hs_on, o_aux_hs_on}, 16'h6);
        i_die_hot = 1'h0;
        wait_fault(1'h0, 0, 8);
        conclude();
    end
endmodule
